// ===== core/decode_pkg.sv
// Constants, encodings and register map of the bit, branch, call and clear decoder.
package decode_pkg;

  localparam int PC_W      = 21;
  localparam int DADDR_W   = 12;
  localparam int STACK_N   = 31;
  localparam int SP_W      = 5;

  // Opcode patterns.
  localparam logic [3:0] OP_BIT_TOGGLE  = 4'h7;
  localparam logic [6:0] OP_CLEAR       = 7'h35;
  localparam logic [7:0] OP_BRANCH_OV   = 8'he4;
  localparam logic [7:0] OP_BRANCH_Z    = 8'he0;
  localparam logic [6:0] OP_CALL        = 7'h76;
  localparam logic [3:0] OP_CALL_SECOND = 4'hf;

  // Instruction field positions.
  localparam int F_ACCESS = 8;
  localparam int F_SHADOW = 8;
  localparam int F_BIT_LO = 9;

  // Status flag positions.
  localparam int ST_Z  = 2;
  localparam int ST_OV = 3;

  // Address formation.
  localparam logic [7:0]         INDEXED_MAX  = 8'h5f;
  localparam logic [7:0]         ACCESS_SPLIT = 8'h60;
  localparam logic [3:0]         ACCESS_HIGH  = 4'hf;
  localparam logic [3:0]         ACCESS_LOW   = 4'h0;

  // Quarter phases of an instruction cycle.
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;

  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] PC_RST  = 21'h000000;

  // Register map, byte addresses.
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_WORK   = 8'h08;
  localparam logic [7:0] A_BANK   = 8'h0c;
  localparam logic [7:0] A_PC     = 8'h10;
  localparam logic [7:0] A_SHADOW = 8'h14;
  localparam logic [7:0] A_STACK  = 8'h18;

  typedef enum logic [0:0] {
    EXEC  = 1'b0,
    FLUSH = 1'b1
  } seq_type;

endpackage

// ===== core/data_address_unit.sv
// Data memory address formation for byte and bit instructions.
`timescale 1ns/1ps
module data_address_unit
  import decode_pkg::*;
(
  input  wire logic [7:0]         field_i,
  input  wire logic               access_i,
  input  wire logic [3:0]         bank_i,
  input  wire logic               ext_en_i,
  input  wire logic [DADDR_W-1:0] index_base_i,
  output logic      [DADDR_W-1:0] addr_o
);

  always_comb begin
    if (access_i) begin
      addr_o = {bank_i, field_i};
    end else if (ext_en_i && field_i <= INDEXED_MAX) begin
      addr_o = index_base_i + {4'h0, field_i};
    end else if (field_i < ACCESS_SPLIT) begin
      addr_o = {ACCESS_LOW, field_i};
    end else begin
      addr_o = {ACCESS_HIGH, field_i};
    end
  end

endmodule

// ===== core/bit_branch_call_clear_exec.sv
// Quarter-cycle decode and execute of bit toggle, branches, call and clear with APB register access.
`timescale 1ns/1ps
module bit_branch_call_clear_exec
  import decode_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               ce_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [7:0]         paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic      [31:0]        prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  output logic      [PC_W-1:0]    pc_o,
  input  wire logic [15:0]        instr_i,
  input  wire logic [DADDR_W-1:0] index_base_i,
  output logic      [DADDR_W-1:0] dmem_addr_o,
  output logic                    dmem_rd_o,
  input  wire logic [7:0]         dmem_rdata_i,
  output logic                    dmem_wr_o,
  output logic      [7:0]         dmem_wdata_o
);

  typedef struct packed {
    seq_type                          seq;
    logic [1:0]                       qph;
    logic [15:0]                      ir;
    logic [PC_W-1:0]                  pc;
    logic [DADDR_W-1:0]               addr;
    logic                             rd;
    logic                             wr;
    logic [7:0]                       data;
    logic [7:0]                       wdata;
    logic                             ext_en;
    logic [7:0]                       working;
    logic [7:0]                       status;
    logic [3:0]                       bank_select_register;
    logic [7:0]                       working_shadow;
    logic [7:0]                       status_shadow;
    logic [3:0]                       bank_select_shadow;
    logic [STACK_N-1:0][PC_W-1:0]     stack;
    logic [SP_W-1:0]                  sp;
    logic                             stack_full;
    logic [31:0]                      prdata;
  } state_type;

  state_type s_q;
  state_type s_d;

  logic [DADDR_W-1:0] ea;
  logic               setup;
  logic               wr_acc;
  logic               mapped;
  logic [PC_W-1:0]    stack_top;

  function automatic logic is_bit_toggle(input logic [15:0] w);
    return w[15:12] == OP_BIT_TOGGLE;
  endfunction

  function automatic logic is_clear(input logic [15:0] w);
    return w[15:9] == OP_CLEAR;
  endfunction

  function automatic logic is_call(input logic [15:0] w);
    return w[15:9] == OP_CALL;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return a == A_CTRL || a == A_STATUS || a == A_WORK || a == A_BANK ||
           a == A_PC || a == A_SHADOW || a == A_STACK;
  endfunction

  function automatic logic branch_taken(input logic [15:0] w, input logic [7:0] st);
    return (w[15:8] == OP_BRANCH_OV && st[ST_OV]) ||
           (w[15:8] == OP_BRANCH_Z && st[ST_Z]);
  endfunction

  data_address_unit u_addr (
    .field_i      (instr_i[7:0]),
    .access_i     (instr_i[F_ACCESS]),
    .bank_i       (s_q.bank_select_register),
    .ext_en_i     (s_q.ext_en),
    .index_base_i (index_base_i),
    .addr_o       (ea)
  );

  assign stack_top = (s_q.sp == '0) ? PC_RST : s_q.stack[s_q.sp - SP_W'(1)];
  assign setup     = psel_i & ~penable_i;
  assign wr_acc    = psel_i & penable_i & pwrite_i & ce_i;
  assign mapped    = is_mapped(paddr_i);

  // Registers answer without wait states; a frozen block holds the bus off.
  assign pready_o  = ce_i;
  assign pslverr_o = psel_i & penable_i & ~mapped;

  always_comb begin
    s_d = s_q;

    // Software writes land first so a same-cycle hardware update wins.
    if (wr_acc && mapped) begin
      unique case (paddr_i)
        A_CTRL:   s_d.ext_en = pwdata_i[0];
        A_STATUS: s_d.status = pwdata_i[7:0];
        A_WORK:   s_d.working = pwdata_i[7:0];
        A_BANK:   s_d.bank_select_register = pwdata_i[3:0];
        default:  s_d.ext_en = s_q.ext_en;
      endcase
    end

    if (setup) begin
      unique case (paddr_i)
        A_CTRL:   s_d.prdata = {31'h00000000, s_q.ext_en};
        A_STATUS: s_d.prdata = {24'h000000, s_q.status};
        A_WORK:   s_d.prdata = {24'h000000, s_q.working};
        A_BANK:   s_d.prdata = {28'h0000000, s_q.bank_select_register};
        A_PC:     s_d.prdata = {11'h000, s_q.pc};
        A_SHADOW: s_d.prdata = {12'h000, s_q.bank_select_shadow, s_q.status_shadow, s_q.working_shadow};
        A_STACK:  s_d.prdata = {5'h00, s_q.stack_full, s_q.sp, stack_top};
        default:  s_d.prdata = 32'h00000000;
      endcase
    end

    s_d.qph = s_q.qph + 2'h1;

    unique case (s_q.qph)
      Q1: begin
        if (s_q.seq == EXEC) begin
          s_d.ir   = instr_i;
          s_d.pc   = s_q.pc + PC_STEP;
          s_d.addr = ea;
          s_d.rd   = is_bit_toggle(instr_i) | is_clear(instr_i);
        end
      end
      Q2: begin
        s_d.rd = 1'b0;
        if (s_q.rd) begin
          s_d.data = dmem_rdata_i;
        end
      end
      Q3: begin
        if (s_q.seq == EXEC) begin
          if (is_bit_toggle(s_q.ir)) begin
            s_d.wdata = s_q.data ^ (8'h01 << s_q.ir[F_BIT_LO +: 3]);
            s_d.wr    = 1'b1;
          end else if (is_clear(s_q.ir)) begin
            s_d.wdata = 8'h00;
            s_d.wr    = 1'b1;
          end else if (is_call(s_q.ir)) begin
            // A full stack drops the push and raises a sticky flag.
            if (s_q.sp < SP_W'(STACK_N)) begin
              s_d.stack[s_q.sp] = s_q.pc + PC_STEP;
              s_d.sp            = s_q.sp + SP_W'(1);
            end else begin
              s_d.stack_full = 1'b1;
            end
            if (s_q.ir[F_SHADOW]) begin
              s_d.working_shadow     = s_q.working;
              s_d.status_shadow      = s_q.status;
              s_d.bank_select_shadow = s_q.bank_select_register;
            end
          end
        end
      end
      Q4: begin
        s_d.wr  = 1'b0;
        s_d.seq = EXEC;
        if (s_q.seq == EXEC) begin
          if (is_clear(s_q.ir)) begin
            s_d.status[ST_Z] = 1'b1;
          end
          if (branch_taken(s_q.ir, s_q.status)) begin
            s_d.pc  = s_q.pc + {{(PC_W-9){s_q.ir[7]}}, s_q.ir[7:0], 1'b0};
            s_d.seq = FLUSH;
          end else if (is_call(s_q.ir) && instr_i[15:12] == OP_CALL_SECOND) begin
            s_d.pc  = {instr_i[11:0], s_q.ir[7:0], 1'b0};
            s_d.seq = FLUSH;
          end
        end
      end
      default: s_d.qph = Q1;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q                      <= '0;
      s_q.seq                  <= EXEC;
      s_q.qph                  <= Q1;
      s_q.pc                   <= PC_RST;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign prdata_o     = s_q.prdata;
  assign pc_o         = s_q.pc;
  assign dmem_addr_o  = s_q.addr;
  assign dmem_rd_o    = s_q.rd;
  assign dmem_wr_o    = s_q.wr;
  assign dmem_wdata_o = s_q.wdata;

endmodule

// ===== verif/exec_assertions.sv
// Checker on the decoder's fetch and data memory ports.
`timescale 1ns/1ps
module exec_checker
  import decode_pkg::*;
(
  input wire logic            clk_i,
  input wire logic            rst_i,
  input wire logic            ce_i,
  input wire logic [PC_W-1:0] pc_o,
  input wire logic [15:0]     instr_i,
  input wire logic            dmem_rd_o,
  input wire logic [7:0]      dmem_rdata_i,
  input wire logic            dmem_wr_o,
  input wire logic [7:0]      dmem_wdata_o
);
  logic [1:0]      ph_q;
  logic [15:0]     ir_q;
  logic [PC_W-1:0] pc1_q;
  // The phase is rebuilt here, so a slip in the design's own counter cannot hide itself.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_q  <= Q1;
      ir_q  <= 16'h0000;
      pc1_q <= PC_RST;
    end else if (ce_i) begin
      ph_q <= ph_q + 2'h1;
      if (ph_q == Q1) begin
        ir_q  <= instr_i;
        pc1_q <= pc_o;
      end
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_PC_STEP: assert property (ph_q == Q1 |=> $stable(pc_o) || pc_o == $past(pc_o) + PC_STEP)
    else $error("pc step wrong");
  AST_PC_HOLD: assert property (ph_q == Q2 || ph_q == Q3 |=> $stable(pc_o))
    else $error("pc moved mid cycle");
  AST_BRANCH: assert property (ph_q == Q4 && pc_o != pc1_q && (ir_q[15:8] == OP_BRANCH_OV ||
    ir_q[15:8] == OP_BRANCH_Z) |=> $stable(pc_o) || pc_o == $past(pc_o) + {{12{ir_q[7]}}, ir_q[7:0], 1'h0})
    else $error("branch target wrong");
  AST_CALL: assert property (ph_q == Q4 && pc_o != pc1_q && ir_q[15:9] == OP_CALL &&
    instr_i[15:12] == OP_CALL_SECOND |=> pc_o == {$past(instr_i[11:0]), ir_q[7:0], 1'h0})
    else $error("call target wrong");
  AST_RD_PHASE: assert property ($rose(dmem_rd_o) |-> ph_q == Q2)
    else $error("read outside second quarter");
  AST_RD_WR: assert property (dmem_rd_o |=> !dmem_rd_o && !dmem_wr_o ##1 dmem_wr_o ##1 !dmem_wr_o)
    else $error("read write spacing wrong");
  AST_TOGGLE: assert property (dmem_rd_o ##2 (dmem_wr_o && ir_q[15:12] == OP_BIT_TOGGLE) |->
    dmem_wdata_o == ($past(dmem_rdata_i, 2) ^ (8'h01 << ir_q[11:9])))
    else $error("toggle data wrong");
  AST_CLEAR: assert property (dmem_wr_o && ir_q[15:9] == OP_CLEAR |-> dmem_wdata_o == 8'h00)
    else $error("clear data not zero");
endmodule

// ===== verif/prog_data_mem.sv
// Program and data memory model on the far side of the decoder.
`timescale 1ns/1ps
module prog_data_mem
  import decode_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic [PC_W-1:0]    pc_i,
  input  wire logic [DADDR_W-1:0] addr_i,
  input  wire logic               rd_i,
  input  wire logic               wr_i,
  input  wire logic [7:0]         wdata_i,
  output logic      [15:0]        instr_o,
  output logic      [7:0]         rdata_o
);
  logic [15:0] rom [64] = '{default: 16'h0000};
  logic [7:0]  ram [4096];
  logic [7:0]  junk_q = 8'h5a;
  // Outside a read the bus shows a changing pattern, so a late sample cannot pass by luck.
  always @(posedge clk_i) begin
    junk_q <= ~junk_q;
    if (wr_i) begin
      ram[addr_i] <= wdata_i;
    end
  end
  assign instr_o = rom[pc_i[6:1]];
  assign rdata_o = rd_i ? ram[addr_i] : junk_q;
endmodule

// ===== verif/tb_top.sv
// Top bench: runs a short program through the decoder and checks memory and registers.
`timescale 1ns/1ps
module tb_top;
  import decode_pkg::*;
  logic               clk_i = 1'h0;
  logic               rst_i = 1'h1;
  logic               psel_i = 1'h0;
  logic               penable_i = 1'h0;
  logic               pwrite_i = 1'h0;
  logic [7:0]         paddr_i = 8'h00;
  logic [31:0]        pwdata_i = 32'h0;
  logic [31:0]        prdata_o, rd_q;
  logic               pready_o, pslverr_o, err_q, dmem_rd_o, dmem_wr_o;
  logic [PC_W-1:0]    pc_o;
  logic [15:0]        instr_i;
  logic [DADDR_W-1:0] dmem_addr_o;
  logic [7:0]         dmem_rdata_i, dmem_wdata_o;
  int                 n_fail = 0;
  int                 checks_done = 0;
  always #25 clk_i = ~clk_i;
  bit_branch_call_clear_exec u_bit_branch_call_clear_exec (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .pc_o(pc_o), .instr_i(instr_i),
    .index_base_i(12'h200), .dmem_addr_o(dmem_addr_o), .dmem_rd_o(dmem_rd_o), .dmem_rdata_i(dmem_rdata_i),
    .dmem_wr_o(dmem_wr_o), .dmem_wdata_o(dmem_wdata_o));
  prog_data_mem u_mem (.clk_i(clk_i), .pc_i(pc_o), .addr_i(dmem_addr_o), .rd_i(dmem_rd_o), .wr_i(dmem_wr_o),
    .wdata_i(dmem_wdata_o), .instr_o(instr_i), .rdata_o(dmem_rdata_i));
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    psel_i   <= 1'h1;
    pwrite_i <= wr;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'h1;
    @(posedge clk_i);
    while (pready_o !== 1'h1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20) begin
      n_fail++;
      end_sim();
    end
    rd_q  = prdata_o;
    err_q = pslverr_o;
    psel_i    <= 1'h0;
    penable_i <= 1'h0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic mem_chk(input logic [11:0] a, input logic [7:0] exp);
    chk({24'h0, u_mem.ram[a]}, {24'h0, exp});
  endtask
  task automatic end_sim();
    if (n_fail == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk_i);
    n_fail++;
    end_sim();
  end
  initial begin
    u_mem.rom[0]  = 16'h6a20;
    u_mem.rom[1]  = 16'he0ff;
    u_mem.rom[2]  = 16'h7e10;
    u_mem.rom[3]  = 16'h7070;
    u_mem.rom[4]  = 16'h7705;
    u_mem.rom[5]  = 16'he402;
    u_mem.rom[6]  = 16'h6b30;
    u_mem.rom[8]  = 16'hed20;
    u_mem.rom[9]  = 16'hf000;
    u_mem.rom[32] = 16'he010;
    u_mem.rom[33] = 16'h6a7f;
    u_mem.rom[34] = 16'he0ff;
    u_mem.ram[12'h020] = 8'hff;
    u_mem.ram[12'h210] = 8'h0f;
    u_mem.ram[12'hf70] = 8'h00;
    u_mem.ram[12'h305] = 8'h00;
    u_mem.ram[12'h330] = 8'h55;
    u_mem.ram[12'hf7f] = 8'h77;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    // The clear sets the zero flag, which parks the program in a branch loop until the bench clears it.
    repeat (40) @(posedge clk_i);
    mem_chk(12'h020, 8'h00);
    apb(1'h0, A_STATUS, 32'h0);
    chk(rd_q, 32'h4);
    chk({31'h0, pc_o == 21'h2 || pc_o == 21'h4}, 32'h1);
    apb(1'h1, A_CTRL, 32'h1);
    apb(1'h1, A_BANK, 32'h3);
    apb(1'h1, A_WORK, 32'h5a);
    apb(1'h1, A_STATUS, 32'h8);
    repeat (200) @(posedge clk_i);
    mem_chk(12'h210, 8'h8f);
    mem_chk(12'hf70, 8'h01);
    mem_chk(12'h305, 8'h08);
    mem_chk(12'h330, 8'h55);
    mem_chk(12'hf7f, 8'h00);
    apb(1'h0, A_SHADOW, 32'h0);
    chk(rd_q, 32'h3085a);
    apb(1'h0, A_STACK, 32'h0);
    chk(rd_q, 32'h200014);
    apb(1'h0, A_STATUS, 32'h0);
    chk(rd_q, 32'hc);
    chk({31'h0, pc_o == 21'h44 || pc_o == 21'h46}, 32'h1);
    apb(1'h0, 8'h1c, 32'h0);
    chk({rd_q[30:0], err_q}, 32'h1);
    end_sim();
  end
endmodule
bind bit_branch_call_clear_exec exec_checker u_exec_checker (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .pc_o(pc_o), .instr_i(instr_i), .dmem_rd_o(dmem_rd_o), .dmem_rdata_i(dmem_rdata_i), .dmem_wr_o(dmem_wr_o),
  .dmem_wdata_o(dmem_wdata_o));
